// ===== sfpp_page_program.sv
`timescale 1ns/1ps
module sfpp_page_program
	import sfpp_pkg::*;
#(
	parameter int ADDR_W         = sfpp_pkg::ADDR_BITS,
	parameter int PAGE_W         = sfpp_pkg::PAGE_BITS,
	parameter int SECTOR_W       = sfpp_pkg::SECTOR_BITS,
	parameter int ARRAY_AW       = sfpp_pkg::ARRAY_ADDR_BITS,
	parameter int PP_CYCLES      = sfpp_pkg::PAGE_PROGRAM_CYCLES,
	parameter int TIMEOUT_CYCLES = sfpp_pkg::PROGRAM_TIMEOUT_CYCLES
) (
	input  wire logic                   clock_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   link_clk_in,
	input  wire logic                   link_cs_n_in,
	input  wire logic [3:0]             serial_data_lines_in,
	input  wire sfpp_pkg::sfpp_proto_t  proto_mode_in,
	input  wire logic [(1<<(ADDR_W-SECTOR_W))-1:0] sector_lock_in,
	input  wire logic                   program_stall_in,
	input  wire logic [ARRAY_AW-1:0]    array_rd_addr_in,
	output logic                        status_wip_out,
	output logic                        status_wel_out,
	output logic      [7:0]             flag_status_out,
	output logic      [7:0]             array_rd_data_out
);
	import sfpp_pkg::*;

	localparam int PAGE_BYTES = 1 << PAGE_W;

	// ****************************************************************
	// link side state
	// ****************************************************************
	logic                  frame_open;
	logic                  frame_tog;
	sfpp_phase_t           phase;
	logic [5:0]            bit_cnt;
	logic [7:0]            op_reg;
	logic [ADDR_W-1:0]     addr_reg;
	logic [7:0]            byte_sh;
	logic                  got_byte;
	logic [PAGE_W-1:0]     col;
	logic [PAGE_BYTES-1:0] mask;
	logic [7:0]            page_buf [PAGE_BYTES];
	logic [2:0]            link_sync;
	logic                  link_busy;
	logic [1:0]            link_proto;
	sfpp_phase_t           cur_phase;
	logic [5:0]            cur_cnt;
	logic [2:0]            lanes;
	logic [5:0]            next_cnt;
	logic [ADDR_W-1:0]     cur_shift;
	logic [ADDR_W-1:0]     next_shift;
	logic                  byte_done;

	// ****************************************************************
	// system side state
	// ****************************************************************
	logic [1:0]            sys_sync;
	logic                  cs_prev;
	logic                  seen_tog;
	logic                  frame_end;
	sfpp_state_t           state;
	logic [PAGE_W-1:0]     col_idx;
	logic [ADDR_W-PAGE_W-1:0] base;
	logic [31:0]           elapsed;
	logic [PAGE_BYTES-1:0] sys_mask;
	logic                  suspended;
	logic                  cmd_done;
	logic                  prog_op;
	logic                  frame_ok;
	logic                  locked;
	logic                  start_try;
	logic                  start_go;
	logic                  finish;
	logic                  fail;
	logic                  is_op_we;
	logic                  is_op_wd;
	logic                  is_op_susp;
	logic                  is_op_res;
	logic                  is_op_clr;
	logic                  arr_en;
	logic [ARRAY_AW-1:0]   arr_addr;
	logic [ADDR_W-1:0]     full_addr;

	function automatic logic is_program(input logic [7:0] op);
		return (op == OP_PAGE_PROGRAM) ||
		       (op == OP_DUAL_DATA_PROGRAM) ||
		       (op == OP_DUAL_FULL_PROGRAM) ||
		       (op == OP_QUAD_DATA_PROGRAM) ||
		       (op == OP_QUAD_FULL_PROGRAM);
	endfunction

	// lines in use for the current phase of the frame
	function automatic logic [2:0] lane_count(input logic [1:0] proto,
		input sfpp_phase_t ph, input logic [7:0] op);
		logic [2:0] w;
		w = 3'd1;
		if (proto == PROTO_DUAL) begin
			w = 3'd2;
		end else if (proto == PROTO_QUAD) begin
			w = 3'd4;
		end else if (ph == PH_ADDR) begin
			if (op == OP_DUAL_FULL_PROGRAM) begin
				w = 3'd2;
			end else if (op == OP_QUAD_FULL_PROGRAM) begin
				w = 3'd4;
			end
		end else if (ph == PH_DATA) begin
			if (op == OP_DUAL_DATA_PROGRAM || op == OP_DUAL_FULL_PROGRAM) begin
				w = 3'd2;
			end else if (op == OP_QUAD_DATA_PROGRAM ||
				op == OP_QUAD_FULL_PROGRAM) begin
				w = 3'd4;
			end
		end
		return w;
	endfunction

	function automatic logic [ADDR_W-1:0] shift_in(
		input logic [ADDR_W-1:0] cur, input logic [2:0] w,
		input logic [3:0] d);
		logic [ADDR_W-1:0] r;
		r = {cur[ADDR_W-2:0], d[0]};
		if (w == 3'd2) begin
			r = {cur[ADDR_W-3:0], d[1:0]};
		end else if (w == 3'd4) begin
			r = {cur[ADDR_W-5:0], d[3:0]};
		end
		return r;
	endfunction

	// ****************************************************************
	// link clock domain
	// ****************************************************************
	sfpp_sync2 #(.W(3), .RST_VAL(3'b000)) u_link_sync (
		.clk_in (link_clk_in),
		.rst_in (1'b0),
		.d_in   ({status_wip_out, proto_mode_in}),
		.q_out  (link_sync)
	);
	assign link_busy  = link_sync[2];
	assign link_proto = link_sync[1:0];

	// first edge of a frame starts from a clean decode
	always_ff @(posedge link_clk_in or posedge link_cs_n_in) begin
		if (link_cs_n_in) begin
			frame_open <= 1'b0;
		end else begin
			frame_open <= 1'b1;
		end
	end

	always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_tog <= 1'b0;
		end else if (!frame_open) begin
			frame_tog <= ~frame_tog;
		end
	end

	always_comb begin
		cur_phase = frame_open ? phase : PH_OPCODE;
		cur_cnt   = frame_open ? bit_cnt : 6'h00;
		lanes     = lane_count(link_proto, cur_phase, op_reg);
		next_cnt  = cur_cnt + {3'h0, lanes};
		unique case (cur_phase)
			PH_OPCODE: cur_shift = {{(ADDR_W-8){1'b0}}, op_reg};
			PH_DATA:   cur_shift = {{(ADDR_W-8){1'b0}}, byte_sh};
			PH_ADDR:   cur_shift = addr_reg;
			PH_IGNORE: cur_shift = addr_reg;
		endcase
		next_shift = shift_in(cur_shift, lanes, serial_data_lines_in);
		byte_done  = (cur_phase == PH_DATA) && (next_cnt == 6'h08);
	end

	// every field bit is taken on the rising serial clock
	always_ff @(posedge link_clk_in) begin
		unique case (cur_phase)
			PH_OPCODE: begin
				op_reg <= next_shift[7:0];
				if (next_cnt == 6'h08) begin
					phase   <= is_program(next_shift[7:0]) ? PH_ADDR : PH_IGNORE;
					bit_cnt <= 6'h00;
				end else begin
					phase   <= PH_OPCODE;
					bit_cnt <= next_cnt;
				end
			end
			PH_ADDR: begin
				addr_reg <= next_shift;
				if (next_cnt == 6'(ADDR_W)) begin
					phase   <= PH_DATA;
					bit_cnt <= 6'h00;
					col     <= next_shift[PAGE_W-1:0];
				end else begin
					bit_cnt <= next_cnt;
				end
			end
			PH_DATA: begin
				byte_sh <= next_shift[7:0];
				if (byte_done) begin
					bit_cnt <= 6'h00;
					col     <= col + PAGE_W'(1);
				end else begin
					bit_cnt <= next_cnt;
				end
			end
			PH_IGNORE: begin
				phase <= PH_IGNORE;
			end
		endcase
	end

	always_ff @(posedge link_clk_in) begin
		if (!frame_open) begin
			got_byte <= 1'b0;
			mask     <= '0;
		end else if (byte_done && !link_busy) begin
			got_byte  <= 1'b1;
			mask[col] <= 1'b1;
		end
	end

	// a later byte to the same column replaces the earlier one
	always_ff @(posedge link_clk_in) begin
		if (byte_done && !link_busy) begin
			page_buf[col] <= next_shift[7:0];
		end
	end

	// ****************************************************************
	// frame end detection
	// ****************************************************************
	sfpp_sync2 #(.W(2), .RST_VAL(2'b01)) u_sys_sync (
		.clk_in (clock_in),
		.rst_in (sys_rst_in),
		.d_in   ({frame_tog, link_cs_n_in}),
		.q_out  (sys_sync)
	);

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			cs_prev  <= 1'b1;
			seen_tog <= 1'b0;
		end else begin
			cs_prev <= sys_sync[0];
			if (frame_end) begin
				seen_tog <= sys_sync[1];
			end
		end
	end

	// link fields stay still once the serial clock has stopped
	always_comb begin
		frame_end  = sys_sync[0] && !cs_prev && (sys_sync[1] != seen_tog);
		cmd_done   = (phase != PH_OPCODE) && frame_end;
		is_op_we   = cmd_done && (op_reg == OP_WRITE_ENABLE);
		is_op_wd   = cmd_done && (op_reg == OP_WRITE_DISABLE);
		is_op_susp = cmd_done && (op_reg == OP_SUSPEND);
		is_op_res  = cmd_done && (op_reg == OP_RESUME);
		is_op_clr  = cmd_done && (op_reg == OP_CLEAR_FLAGS);
		prog_op    = is_program(op_reg);
		frame_ok   = (phase == PH_DATA) && (bit_cnt == 6'h00) && got_byte;
		locked     = sector_lock_in[addr_reg[ADDR_W-1:SECTOR_W]];
		start_try  = frame_end && prog_op && frame_ok && status_wel_out &&
		             (state == ST_IDLE) && !suspended;
		start_go   = start_try && !locked;
		finish     = (state == ST_WAIT) && !suspended && !program_stall_in &&
		             (elapsed >= 32'(PP_CYCLES));
		fail       = (state == ST_WAIT) && !suspended && !finish &&
		             (elapsed >= 32'(TIMEOUT_CYCLES));
	end

	// ****************************************************************
	// self-timed program sequencer
	// ****************************************************************
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state    <= ST_IDLE;
			col_idx  <= '0;
			base     <= '0;
			elapsed  <= 32'h0;
			sys_mask <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_go) begin
						state    <= ST_WRITE;
						col_idx  <= '0;
						elapsed  <= 32'h0;
						base     <= addr_reg[ADDR_W-1:PAGE_W];
						sys_mask <= mask;
					end
				end
				ST_WRITE: begin
					if (!suspended) begin
						elapsed <= elapsed + 32'h1;
						col_idx <= col_idx + PAGE_W'(1);
						if (&col_idx) begin
							state <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (finish || fail) begin
						state <= ST_IDLE;
					end else if (!suspended) begin
						elapsed <= elapsed + 32'h1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			suspended <= 1'b0;
		end else if (is_op_susp && state != ST_IDLE && !finish && !fail) begin
			suspended <= 1'b1;
		end else if (is_op_res) begin
			suspended <= 1'b0;
		end
	end

	// only columns that received a byte are touched
	assign full_addr = {base, col_idx};
	assign arr_addr  = full_addr[ARRAY_AW-1:0];
	assign arr_en    = (state == ST_WRITE) && !suspended && sys_mask[col_idx];

	sfpp_flash_array #(.AW(ARRAY_AW)) u_array (
		.clk_in       (clock_in),
		.prog_en_in   (arr_en),
		.prog_addr_in (arr_addr),
		.prog_data_in (page_buf[col_idx]),
		.rd_addr_in   (array_rd_addr_in),
		.rd_data_out  (array_rd_data_out)
	);

	// ****************************************************************
	// status and flag status
	// ****************************************************************
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			status_wip_out <= 1'b0;
		end else if (start_go) begin
			status_wip_out <= 1'b1;
		end else if (finish || fail) begin
			status_wip_out <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			status_wel_out <= 1'b0;
		end else if (finish || fail) begin
			status_wel_out <= 1'b0;
		end else if (is_op_we && state == ST_IDLE) begin
			status_wel_out <= 1'b1;
		end else if (is_op_wd && state == ST_IDLE) begin
			status_wel_out <= 1'b0;
		end
	end

	// clear first so a same-cycle error still lands
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			flag_status_out <= FSR_RESET;
		end else begin
			if (is_op_clr) begin
				flag_status_out[FSR_PROG_ERR_BIT] <= 1'b0;
				flag_status_out[FSR_PROT_BIT]     <= 1'b0;
			end
			if (start_try && locked) begin
				flag_status_out[FSR_PROG_ERR_BIT] <= 1'b1;
				flag_status_out[FSR_PROT_BIT]     <= 1'b1;
			end
			if (fail) begin
				flag_status_out[FSR_PROG_ERR_BIT] <= 1'b1;
			end
			if (start_go || (is_op_res && suspended)) begin
				flag_status_out[FSR_READY_BIT] <= 1'b0;
			end else if (finish || fail ||
				(is_op_susp && state != ST_IDLE)) begin
				flag_status_out[FSR_READY_BIT] <= 1'b1;
			end
			if (is_op_susp && state != ST_IDLE && !finish && !fail) begin
				flag_status_out[FSR_PROG_SUSP_BIT] <= 1'b1;
			end else if (is_op_res) begin
				flag_status_out[FSR_PROG_SUSP_BIT] <= 1'b0;
			end
		end
	end
endmodule

// ===== sfpp_pkg.sv
package sfpp_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int ADDR_BITS       = 24;
	localparam int PAGE_BITS       = 8;
	localparam int SECTOR_BITS     = 16;
	localparam int ARRAY_ADDR_BITS = 12;

	// ****************************************************************
	// command codes
	// ****************************************************************
	localparam logic [7:0] OP_PAGE_PROGRAM      = 8'h02;
	localparam logic [7:0] OP_DUAL_DATA_PROGRAM = 8'ha2;
	localparam logic [7:0] OP_DUAL_FULL_PROGRAM = 8'hd2;
	localparam logic [7:0] OP_QUAD_DATA_PROGRAM = 8'h32;
	localparam logic [7:0] OP_QUAD_FULL_PROGRAM = 8'h38;
	localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE     = 8'h04;
	localparam logic [7:0] OP_SUSPEND           = 8'h75;
	localparam logic [7:0] OP_RESUME            = 8'h7a;
	localparam logic [7:0] OP_CLEAR_FLAGS       = 8'h50;

	// ****************************************************************
	// flag status layout
	// ****************************************************************
	localparam int         FSR_READY_BIT     = 7;
	localparam int         FSR_PROG_ERR_BIT  = 4;
	localparam int         FSR_PROG_SUSP_BIT = 2;
	localparam int         FSR_PROT_BIT      = 1;
	localparam logic [7:0] FSR_RESET         = 8'h80;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLOCK_MHZ            = 100;
	localparam int PAGE_PROGRAM_TIME_US = 120;
	localparam int PROGRAM_TIMEOUT_US   = 1000;
	localparam int PAGE_PROGRAM_CYCLES  = PAGE_PROGRAM_TIME_US * CLOCK_MHZ;
	localparam int PROGRAM_TIMEOUT_CYCLES = PROGRAM_TIMEOUT_US * CLOCK_MHZ;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		PROTO_EXT  = 2'b00,
		PROTO_DUAL = 2'b01,
		PROTO_QUAD = 2'b10
	} sfpp_proto_t;

	typedef enum logic [1:0] {
		PH_OPCODE = 2'b00,
		PH_ADDR   = 2'b01,
		PH_DATA   = 2'b10,
		PH_IGNORE = 2'b11
	} sfpp_phase_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_WAIT  = 2'b10
	} sfpp_state_t;

endpackage

// ===== sfpp_sync2.sv
`timescale 1ns/1ps
module sfpp_sync2 #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta  <= RST_VAL;
			q_out <= RST_VAL;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule

// ===== sfpp_flash_array.sv
`timescale 1ns/1ps
module sfpp_flash_array #(
	parameter int AW = 12
) (
	input  wire logic          clk_in,
	input  wire logic          prog_en_in,
	input  wire logic [AW-1:0] prog_addr_in,
	input  wire logic [7:0]    prog_data_in,
	input  wire logic [AW-1:0] rd_addr_in,
	output logic      [7:0]    rd_data_out
);
	logic [7:0] cells [1<<AW];

	// erased array
	initial begin
		for (int i = 0; i < (1 << AW); i++) begin
			cells[i] = 8'hff;
		end
	end

	always_ff @(posedge clk_in) begin
		if (prog_en_in) begin
			cells[prog_addr_in] <= cells[prog_addr_in] & prog_data_in;
		end
		rd_data_out <= cells[rd_addr_in];
	end
endmodule

// ===== sfpp_page_program_chk.sv
`timescale 1ns/1ps
module sfpp_page_program_chk #(
	parameter int PP_CYCLES      = 300,
	parameter int TIMEOUT_CYCLES = 600
) (
	input wire logic       clock_in,
	input wire logic       sys_rst_in,
	input wire logic       status_wip_out,
	input wire logic       status_wel_out,
	input wire logic [7:0] flag_status_out
);
	logic [31:0] run_cnt;
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);
	// ****************
	// busy time, paused while suspended
	// ****************
	always_ff @(posedge clock_in) begin
		if (sys_rst_in || !status_wip_out) begin
			run_cnt <= '0;
		end else if (!flag_status_out[2]) begin
			run_cnt <= run_cnt + 32'h1;
		end
	end
	property p_wel_end;
		$fell(status_wip_out) |-> !status_wel_out;
	endproperty
	a_wel_end: assert property (p_wel_end)
		else $error("latch still set after program end");
	property p_busy;
		status_wip_out && !flag_status_out[2] |-> !flag_status_out[7];
	endproperty
	a_busy: assert property (p_busy)
		else $error("ready shown while programming");
	property p_done;
		$fell(status_wip_out) |-> flag_status_out[7];
	endproperty
	a_done: assert property (p_done)
		else $error("not ready after program end");
	property p_fail;
		$rose(flag_status_out[4]) && !flag_status_out[1]
			|-> $fell(status_wip_out) && !status_wel_out;
	endproperty
	a_fail: assert property (p_fail)
		else $error("failure flag without program end");
	property p_prot;
		$rose(flag_status_out[1]) |-> flag_status_out[4]
			&& status_wel_out && !status_wip_out;
	endproperty
	a_prot: assert property (p_prot)
		else $error("protection refusal state wrong");
	property p_susp;
		flag_status_out[2] |-> status_wip_out && flag_status_out[7];
	endproperty
	a_susp: assert property (p_susp)
		else $error("suspend flag without paused program");
	property p_zero;
		flag_status_out[6:5] == 2'h0 && !flag_status_out[3]
			&& !flag_status_out[0];
	endproperty
	a_zero: assert property (p_zero)
		else $error("unused flag bit set");
	property p_min;
		$fell(status_wip_out) && !flag_status_out[4]
			|-> run_cnt >= PP_CYCLES - 8;
	endproperty
	a_min: assert property (p_min)
		else $error("program ended too early");
	property p_max;
		status_wip_out |-> run_cnt <= TIMEOUT_CYCLES + 8;
	endproperty
	a_max: assert property (p_max)
		else $error("program ran past timeout");
endmodule
bind sfpp_page_program sfpp_page_program_chk #(
	.PP_CYCLES      (PP_CYCLES),
	.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
) chk_u (
	.clock_in        (clock_in),
	.sys_rst_in      (sys_rst_in),
	.status_wip_out  (status_wip_out),
	.status_wel_out  (status_wel_out),
	.flag_status_out (flag_status_out)
);

// ===== sfpp_host_model.sv
`timescale 1ns/1ps
module sfpp_host_model (
	output logic       link_clk_out,
	output logic       link_cs_n_out,
	output logic [3:0] data_lines_out
);
	initial begin
		link_clk_out   = 1'b0;
		link_cs_n_out  = 1'b0;
		data_lines_out = 4'h0;
		// an edge on select puts the frame decode into a known state
		#1 link_cs_n_out = 1'b1;
	end
	// ****************
	// serial shifting, clock only inside frames
	// ****************
	task automatic shift(input logic [23:0] v, input int nb, input int ln);
		for (int i = nb - ln; i >= 0; i -= ln) begin
			for (int k = 0; k < 4; k++) begin
				data_lines_out[k] = (k < ln) ? v[i + k] : ~data_lines_out[k];
			end
			#16 link_clk_out = 1'b1;
			#16 link_clk_out = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] op, input int ol, input int al,
		input int dl, input logic [23:0] a, input logic [7:0] d[$],
		input int extra);
		link_cs_n_out = 1'b0;
		#7;
		shift({16'h0, op}, 8, ol);
		if (al > 0) begin
			shift(a, 24, al);
		end
		foreach (d[j]) begin
			shift({16'h0, d[j]}, 8, dl);
		end
		if (extra > 0) begin
			shift(24'h0, extra, dl);
		end
		#9;
		link_cs_n_out = 1'b1;
		data_lines_out = ~data_lines_out;
		#60;
	endtask
endmodule

// ===== sfpp_page_program_tb.sv
`timescale 1ns/1ps
module sfpp_page_program_tb;
	import sfpp_pkg::*;
	logic        clock_in   = 1'b0;
	logic        sys_rst_in = 1'b0;
	logic        lclk, lcs_n, wip, wel, wip_q;
	logic [3:0]  dq;
	sfpp_proto_t proto      = PROTO_EXT;
	logic [255:0] lock      = '0;
	logic        stall      = 1'b0;
	logic [11:0] rd_addr    = '0;
	logic [7:0]  flags, rd_data;
	logic [7:0]  exp_mem [4096];
	logic [8:0]  notes [$];
	logic [7:0]  bytes [$];
	logic [7:0]  ops [5]    = '{OP_PAGE_PROGRAM, OP_DUAL_DATA_PROGRAM,
		OP_DUAL_FULL_PROGRAM, OP_QUAD_DATA_PROGRAM, OP_QUAD_FULL_PROGRAM};
	int          alane [5]  = '{1, 1, 2, 1, 4};
	int          dlane [5]  = '{1, 2, 2, 4, 4};
	int          n_fail = 0, checks_done = 0, seed = 89233, olanes = 1;
	always #5 clock_in = ~clock_in;
	sfpp_host_model host_u (.link_clk_out(lclk), .link_cs_n_out(lcs_n),
		.data_lines_out(dq));
	sfpp_page_program #(.PP_CYCLES(300), .TIMEOUT_CYCLES(600)) dut_u (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in), .link_clk_in(lclk),
		.link_cs_n_in(lcs_n), .serial_data_lines_in(dq),
		.proto_mode_in(proto), .sector_lock_in(lock),
		.program_stall_in(stall), .array_rd_addr_in(rd_addr),
		.status_wip_out(wip), .status_wel_out(wel),
		.flag_status_out(flags), .array_rd_data_out(rd_data));
	// ****************
	// checking and closing
	// ****************
	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		checks_done++;
		if (seen !== want) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(negedge clock_in) begin
		if (wip_q === 1'b1 && wip === 1'b0) begin
			if (notes.size() == 0) begin
				check(9'h0, 9'h1ff);
			end else begin
				check({wel, flags}, notes.pop_front());
			end
		end
		wip_q = wip;
	end
	initial begin
		#400000;
		n_fail++;
		end_sim();
	end
	// ****************
	// stimulus helpers
	// ****************
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		cyc(10);
		while (wip !== 1'b0 && n < 3000) begin
			cyc(1);
			n++;
		end
		check({8'h0, wip}, 9'h0);
	endtask
	task automatic cmd(input logic [7:0] op);
		bytes = {};
		host_u.frame(op, olanes, 0, 1, 24'h0, bytes, 0);
		cyc(6);
	endtask
	task automatic prog(input logic [7:0] op, input int al, input int dl,
		input logic [23:0] a, input int n, input int extra, input bit ok);
		logic [7:0]  b;
		logic [11:0] x;
		bytes = {};
		for (int i = 0; i < n; i++) begin
			b = 8'($random(seed));
			bytes.push_back(b);
			x = {a[11:8], 8'(a[7:0] + i)};
			if (ok && i >= n - 256) begin
				exp_mem[x] = exp_mem[x] & b;
			end
		end
		if (ok) begin
			notes.push_back(9'h080);
		end
		host_u.frame(op, olanes, al, dl, a, bytes, extra);
	endtask
	// ****************
	// scenarios
	// ****************
	initial begin
		wip_q = 1'b0;
		foreach (exp_mem[i]) exp_mem[i] = 8'hff;
		// a real rising edge clears the link side toggle
		#1 sys_rst_in = 1'b1;
		repeat (8) @(posedge clock_in);
		#1 sys_rst_in = 1'b0;
		cyc(3);
		check({wip, flags}, 9'h080);
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h10, 1, 0, 0);
		cyc(40);
		check({wip, wel, flags[7:1]}, 9'h040);
		for (int k = 0; k < 10; k++) begin
			cmd(OP_WRITE_ENABLE);
			check({8'h0, wel}, 9'h1);
			prog(ops[k % 5], alane[k % 5], dlane[k % 5],
				{16'h1, 8'($random(seed))}, 3, 0, 1);
			wait_idle();
		end
		olanes = 2;
		proto = PROTO_DUAL;
		// link side takes a new mode only after two serial clocks
		cmd(OP_WRITE_ENABLE);
		cmd(OP_WRITE_ENABLE);
		prog(OP_DUAL_DATA_PROGRAM, 2, 2, 24'h3fe, 4, 0, 1);
		wait_idle();
		olanes = 4;
		proto = PROTO_QUAD;
		cmd(OP_WRITE_ENABLE);
		cmd(OP_WRITE_ENABLE);
		prog(OP_QUAD_FULL_PROGRAM, 4, 4, 24'h310, 4, 0, 1);
		wait_idle();
		olanes = 1;
		proto = PROTO_EXT;
		cmd(OP_WRITE_ENABLE);
		cmd(OP_WRITE_ENABLE);
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h480, 258, 0, 1);
		wait_idle();
		cmd(OP_WRITE_ENABLE);
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h500, 2, 4, 0);
		cyc(30);
		check({wel, flags}, 9'h180);
		check({8'h0, wip}, 9'h0);
		lock[1] = 1'b1;
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h10020, 1, 0, 0);
		cyc(30);
		check({wel, flags}, 9'h192);
		cmd(OP_CLEAR_FLAGS);
		check({wel, flags}, 9'h180);
		lock[1] = 1'b0;
		cmd(OP_WRITE_DISABLE);
		check({8'h0, wel}, 9'h0);
		cmd(OP_WRITE_ENABLE);
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h600, 2, 0, 1);
		cyc(20);
		cmd(OP_SUSPEND);
		check({wip, flags}, 9'h184);
		cyc(700);
		check({wip, flags}, 9'h184);
		cmd(OP_RESUME);
		check({wip, flags}, 9'h100);
		wait_idle();
		stall = 1'b1;
		cmd(OP_WRITE_ENABLE);
		notes.push_back(9'h090);
		prog(OP_PAGE_PROGRAM, 1, 1, 24'h700, 1, 0, 0);
		wait_idle();
		stall = 1'b0;
		cmd(OP_CLEAR_FLAGS);
		check({wel, flags}, 9'h080);
		for (int i = 0; i < 12'h700; i++) begin
			rd_addr = 12'(i);
			cyc(2);
			check({1'b0, rd_data}, {1'b0, exp_mem[i]});
		end
		check(9'(notes.size()), 9'h0);
		end_sim();
	end
endmodule
